/* File: core/aiau_params.svh */
// timing and reset constants for the analog input averaging and update block
// assumes a single core clock at the rate given by AIAU_CLK_NS
`ifndef AIAU_PARAMS_SVH
`define AIAU_PARAMS_SVH
`define AIAU_CLK_NS      20
`define AIAU_CONV_NS     31250
`define AIAU_UPD_NS      160000
`define AIAU_CONV_CYC    ((`AIAU_CONV_NS) / (`AIAU_CLK_NS))
`define AIAU_UPD_CYC     ((`AIAU_UPD_NS) / (`AIAU_CLK_NS))
`define AIAU_HIST_DEPTH  32
`define AIAU_WIN_NONE    1
`define AIAU_WIN_4       4
`define AIAU_WIN_16      16
`define AIAU_FIFO_DEPTH  4
`define AIAU_SAMPLE_W    16
`define AIAU_FILT_RESET  1'b0
`endif

/* File: core/aiau_pkg.sv */
// types shared by the analog input averaging and update block
// assumes aiau_params.svh supplies all numeric constants
package aiau_pkg;
    typedef enum logic [1:0] {
        AIAU_AVG_NONE,
        AIAU_AVG_4,
        AIAU_AVG_16,
        AIAU_AVG_32
    } aiau_avg_t;
endpackage : aiau_pkg

/* File: core/aiau_top.sv */
// analog input sample fifo, sliding average and periodic process data update
// assumes converter data valid when conv_start pulses; all inputs synchronous to core_clk
`timescale 1ns/1ps
`include "aiau_params.svh"

module aiau_fifo #(
    parameter int WIDTH = `AIAU_SAMPLE_W,
    parameter int DEPTH = `AIAU_FIFO_DEPTH
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PW-1:0]    rd_ptr_r;
    logic [PW-1:0]    wr_ptr_r;
    logic [PW:0]      count_r;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (count_r != (PW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data  = mem[rd_ptr_r];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rd_ptr_r <= '0;
            wr_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : aiau_fifo

module aiau_top #(
    parameter int          W            = `AIAU_SAMPLE_W,
    parameter int          UPD_CYC      = `AIAU_UPD_CYC,
    parameter bit          SYNC_IN_CAP  = 1'b0,
    parameter bit          SYNC_OUT_CAP = 1'b0
) (
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic [W-1:0]       analog_input_signal,
    input  wire logic               cfg_we,
    input  wire aiau_pkg::aiau_avg_t avg_sel,
    input  wire logic               filter_sel,
    output logic                    conv_start,
    output logic                    filter_12k,
    output logic [W-1:0]            pd_value,
    output logic                    pd_update,
    output logic                    input_sync_capable,
    output logic                    output_sync_capable
);
    localparam int CONV_CYC = `AIAU_CONV_CYC;
    localparam int CW       = $clog2(CONV_CYC);
    localparam int UW       = $clog2(UPD_CYC);
    localparam int HD       = `AIAU_HIST_DEPTH;
    localparam int HW       = $clog2(HD);
    localparam int SW       = W + HW + 1;

    function automatic logic [HW:0] aiau_win(input aiau_pkg::aiau_avg_t m);
        unique case (m)
            aiau_pkg::AIAU_AVG_NONE: aiau_win = (HW+1)'(`AIAU_WIN_NONE);
            aiau_pkg::AIAU_AVG_4:    aiau_win = (HW+1)'(`AIAU_WIN_4);
            aiau_pkg::AIAU_AVG_16:   aiau_win = (HW+1)'(`AIAU_WIN_16);
            aiau_pkg::AIAU_AVG_32:   aiau_win = (HW+1)'(HD);
        endcase
    endfunction : aiau_win

    function automatic logic [2:0] aiau_shift(input aiau_pkg::aiau_avg_t m);
        unique case (m)
            aiau_pkg::AIAU_AVG_NONE: aiau_shift = 3'($clog2(`AIAU_WIN_NONE));
            aiau_pkg::AIAU_AVG_4:    aiau_shift = 3'($clog2(`AIAU_WIN_4));
            aiau_pkg::AIAU_AVG_16:   aiau_shift = 3'($clog2(`AIAU_WIN_16));
            aiau_pkg::AIAU_AVG_32:   aiau_shift = 3'($clog2(`AIAU_HIST_DEPTH));
        endcase
    endfunction : aiau_shift

    // conversion timer and sample capture
    logic [CW-1:0]       conv_cnt_r;
    logic                conv_start_r;
    logic                samp_valid_r;
    logic [W-1:0]        samp_r;
    logic                fifo_in_ready;
    wire                 conv_tick = (conv_cnt_r == CW'(CONV_CYC-1));

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            conv_cnt_r   <= '0;
            conv_start_r <= 1'b0;
        end else begin
            conv_cnt_r   <= conv_tick ? '0 : conv_cnt_r + 1'b1;
            conv_start_r <= conv_tick && fifo_in_ready;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            samp_valid_r <= 1'b0;
            samp_r       <= '0;
        end else begin
            samp_valid_r <= conv_start_r;
            samp_r       <= conv_start_r ? analog_input_signal : samp_r;
        end
    end

    // sample buffer between converter and averaging stage
    logic                fifo_out_valid;
    logic [W-1:0]        fifo_out_data;
    logic                busy_r;
    logic                take_ok;
    logic                take;

    aiau_fifo #(.WIDTH(W), .DEPTH(`AIAU_FIFO_DEPTH)) u_fifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (samp_valid_r),
        .in_ready  (fifo_in_ready),
        .in_data   (samp_r),
        .out_valid (fifo_out_valid),
        .out_ready (take_ok),
        .out_data  (fifo_out_data)
    );

    // configuration
    aiau_pkg::aiau_avg_t mode_r;
    logic                filt_r;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_r <= aiau_pkg::AIAU_AVG_16;
            filt_r <= `AIAU_FILT_RESET;
        end else if (cfg_we) begin
            mode_r <= avg_sel;
            filt_r <= filter_sel;
        end
    end

    // sliding window averaging
    logic [W-1:0]        hist [0:HD-1];
    logic [HW-1:0]       wr_ptr_r;
    logic [HW:0]         fill_r;
    logic [SW-1:0]       sum_r;
    logic [W-1:0]        avg_r;
    wire  [HW:0]         win      = aiau_win(mode_r);
    wire  [HW-1:0]       old_idx  = wr_ptr_r - win[HW-1:0];
    wire  [W-1:0]        old_val  = (fill_r >= win) ? hist[old_idx] : '0;
    wire  [SW-1:0]       sum_nxt  = sum_r + SW'(fifo_out_data) - SW'(old_val);
    wire  [SW-1:0]       avg_wide = sum_nxt >> aiau_shift(mode_r);
    wire                 mode_chg = cfg_we && (avg_sel != mode_r);

    // a sample meeting a depth change waits one cycle so it lands in the new window
    assign take_ok = !busy_r && !mode_chg;
    assign take    = fifo_out_valid && take_ok;

    always_ff @(posedge core_clk) begin
        if (take) begin
            hist[wr_ptr_r] <= fifo_out_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            busy_r   <= 1'b0;
            wr_ptr_r <= '0;
            fill_r   <= '0;
            sum_r    <= '0;
            avg_r    <= '0;
        end else begin
            busy_r <= take;
            if (mode_chg) begin
                fill_r <= '0;
                sum_r  <= '0;
            end else if (take) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
                fill_r   <= (fill_r == (HW+1)'(HD)) ? fill_r : fill_r + 1'b1;
                sum_r    <= sum_nxt;
                avg_r    <= (mode_r == aiau_pkg::AIAU_AVG_NONE) ? fifo_out_data
                            : avg_wide[W-1:0];
            end
        end
    end

    // process data update, free-running without sync support
    logic [UW-1:0]       upd_cnt_r;
    logic [W-1:0]        pd_value_r;
    logic                pd_update_r;
    logic                in_sync_r;
    logic                out_sync_r;
    wire                 upd_tick = (upd_cnt_r == UW'(UPD_CYC-1));

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            upd_cnt_r   <= '0;
            pd_value_r  <= '0;
            pd_update_r <= 1'b0;
            in_sync_r   <= 1'b0;
            out_sync_r  <= 1'b0;
        end else begin
            upd_cnt_r   <= upd_tick ? '0 : upd_cnt_r + 1'b1;
            pd_update_r <= upd_tick;
            if (upd_tick) begin
                pd_value_r <= avg_r;
            end
            in_sync_r   <= SYNC_IN_CAP;
            out_sync_r  <= SYNC_OUT_CAP;
        end
    end

    assign conv_start          = conv_start_r;
    assign filter_12k          = filt_r;
    assign pd_value            = pd_value_r;
    assign pd_update           = pd_update_r;
    assign input_sync_capable  = in_sync_r;
    assign output_sync_capable = out_sync_r;

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    wire [W+1:0] four_sum = (W+2)'(fifo_out_data) + (W+2)'(hist[wr_ptr_r - 1'b1])
                          + (W+2)'(hist[wr_ptr_r - 2'h2]) + (W+2)'(hist[wr_ptr_r - 2'h3]);

    sequence s_take_four;
        take && !mode_chg && (mode_r == aiau_pkg::AIAU_AVG_4) && (fill_r >= (HW+1)'(`AIAU_WIN_4));
    endsequence

    sequence s_quiet8;
        !pd_update_r [*8];
    endsequence

    a_four_sample_avg: assert property (s_take_four |=> avg_r == $past(four_sum[W+1:2]))
        else $error("four-sample average wrong");
    a_mode_held: assert property (!cfg_we |=> $stable(mode_r))
        else $error("averaging depth changed without config write");
    a_pd_latch: assert property (upd_tick |=> pd_update_r && (pd_value_r == $past(avg_r)))
        else $error("update did not latch newest average");
    a_pd_spacing: assert property ($rose(pd_update_r) |=> s_quiet8)
        else $error("updates too close together");
    a_pd_hold: assert property (!pd_update_r ##1 !pd_update_r |-> $stable(pd_value_r))
        else $error("presented value changed between updates");
    a_conv_spacing: assert property (conv_start_r |=> !conv_start_r [*8])
        else $error("conversions too close together");
    a_conv_period: assert property (conv_start_r |-> $past(conv_tick))
        else $error("conversion off its interval");
    a_filter_cfg: assert property (cfg_we |=> filt_r == $past(filter_sel))
        else $error("filter setting not applied");
    a_sync_flags: assert property (##1 (in_sync_r == SYNC_IN_CAP) && (out_sync_r == SYNC_OUT_CAP))
        else $error("sync capability flags wrong");
    a_nomean_pass: assert property (take && !mode_chg && mode_r == aiau_pkg::AIAU_AVG_NONE
                                    |=> avg_r == $past(fifo_out_data))
        else $error("no-average mode not passed through");
endmodule : aiau_top

/* File: testbench/aiau_lbus_model.sv */
// local bus, coupler and controller seen from the module's process data port
// assumes pd_value and pd_update come straight from aiau_top on core_clk
`timescale 1ns/1ps

module aiau_lbus_model #(
    parameter int W        = 16,
    parameter int CTRL_CYC = 100,
    parameter int SYNC_CYC = 400
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pd_value,
    input  wire logic         pd_update,
    output logic      [W-1:0] bus_value,
    output logic      [W-1:0] net_value,
    output logic      [W-1:0] img_value,
    output logic              mod_sync
);
    int   ctrl_cnt;
    int   sync_cnt;
    logic sync_clk;

    // clock master sets the sync time points
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync_cnt <= 0;
            sync_clk <= 1'b0;
        end else begin
            sync_cnt <= (sync_cnt == SYNC_CYC - 1) ? 0 : sync_cnt + 1;
            sync_clk <= (sync_cnt == SYNC_CYC - 1);
        end
    end

    // station head relays the sync pulse to the modules
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mod_sync <= 1'b0;
        end else begin
            mod_sync <= sync_clk;
        end
    end

    // bus master takes the presented value
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bus_value <= '0;
        end else if (pd_update) begin
            bus_value <= pd_value;
        end
    end

    // coupler forwards only the value current now
    assign net_value = bus_value;

    // controller copies whatever is current at its cycle start
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_cnt  <= 0;
            img_value <= '0;
        end else if (ctrl_cnt == CTRL_CYC - 1) begin
            ctrl_cnt  <= 0;
            img_value <= net_value;
        end else begin
            ctrl_cnt <= ctrl_cnt + 1;
        end
    end
endmodule : aiau_lbus_model

/* File: testbench/aiau_tb.sv */
// self-checking bench for aiau_top with a small update period
// assumes aiau_params.svh on the include path and the conversion period fixed in the design
`timescale 1ns/1ps
`include "aiau_params.svh"

module tb;
    localparam int UPD = 64;
    logic                core_clk;
    logic                rst_n;
    logic [15:0]         analog_input_signal;
    logic                cfg_we;
    aiau_pkg::aiau_avg_t avg_sel;
    logic                filter_sel;
    logic                conv_start;
    logic                filter_12k;
    logic [15:0]         pd_value;
    logic                pd_update;
    logic                input_sync_capable;
    logic                output_sync_capable;
    logic [15:0]         bus_value;
    logic [15:0]         net_value;
    logic [15:0]         img_value;
    logic                mod_sync;
    int                  error_cnt;
    int                  tests_run;
    int                  hist[$];

    aiau_top #(.UPD_CYC(UPD)) uut (.core_clk(core_clk), .rst_n(rst_n),
        .analog_input_signal(analog_input_signal), .cfg_we(cfg_we), .avg_sel(avg_sel),
        .filter_sel(filter_sel), .conv_start(conv_start), .filter_12k(filter_12k), .pd_value(pd_value),
        .pd_update(pd_update), .input_sync_capable(input_sync_capable),
        .output_sync_capable(output_sync_capable));

    aiau_lbus_model lbus (.core_clk(core_clk), .rst_n(rst_n), .pd_value(pd_value),
        .pd_update(pd_update), .bus_value(bus_value), .net_value(net_value), .img_value(img_value),
        .mod_sync(mod_sync));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    // sel 0 waits for conv_start, sel 1 for pd_update; n gives cycles taken
    task automatic wait_for(input int sel, input int lim, output int n);
        for (n = 1; n <= lim; n++) begin
            @(posedge core_clk);
            #1;
            if ((sel == 0 && conv_start === 1'b1) || (sel == 1 && pd_update === 1'b1)) begin
                return;
            end
        end
        error_cnt++;
        $display("timeout waiting on handshake");
        wrap_up();
    endtask : wait_for

    function automatic logic [15:0] exp_avg(input int sh);
        int s = 0;
        for (int i = 0; i < (1 << sh) && i < hist.size(); i++) begin
            s += hist[hist.size() - 1 - i];
        end
        return 16'(s >> sh);
    endfunction : exp_avg

    task automatic one_sample(input logic [15:0] v, input int sh);
        int n;
        @(posedge core_clk);
        analog_input_signal <= v;
        wait_for(0, `AIAU_CONV_CYC + 10, n);
        hist.push_back(v);
        repeat (10) @(posedge core_clk);
        wait_for(1, UPD + 4, n);
        chk(pd_value, exp_avg(sh));
    endtask : one_sample

    task automatic set_mode(input aiau_pkg::aiau_avg_t m, input logic f);
        @(posedge core_clk);
        cfg_we     <= 1'b1;
        avg_sel    <= m;
        filter_sel <= f;
        @(posedge core_clk);
        cfg_we <= 1'b0;
        @(posedge core_clk);
        #1;
        chk(filter_12k, f);
        hist.delete();
    endtask : set_mode

    task automatic t_reset();
        @(posedge core_clk);
        #1;
        chk({conv_start, pd_update, filter_12k}, 32'h0);
        chk({input_sync_capable, output_sync_capable}, 32'h0);
        chk(pd_value, 32'h0);
    endtask : t_reset

    task automatic t_conv_period();
        int n;
        wait_for(0, `AIAU_CONV_CYC + 10, n);
        wait_for(0, `AIAU_CONV_CYC + 10, n);
        chk(n, `AIAU_CONV_CYC);
    endtask : t_conv_period

    // spans one conversion so a new average appears between two updates
    task automatic t_update_hold();
        int          n;
        int          sync_seen;
        logic [15:0] v;
        logic [15:0] img_last;
        sync_seen = 0;
        @(posedge core_clk);
        analog_input_signal <= 16'h7777;
        for (int k = 0; k < 26; k++) begin
            wait_for(1, UPD + 4, n);
            if (k > 0) begin
                chk(n, 1);
            end
            v        = pd_value;
            img_last = img_value;
            for (int i = 0; i < UPD - 1; i++) begin
                @(posedge core_clk);
                #1;
                chk(pd_value, v);
                chk(bus_value, v);
                chk(net_value, v);
                if (i > 0 && img_value !== img_last) begin
                    chk(img_value, v);
                end
                img_last = img_value;
                if (mod_sync === 1'b1) begin
                    sync_seen++;
                end
            end
        end
        hist.push_back(16'h7777);
        chk(v, exp_avg(4));
        chk(sync_seen != 0, 1'b1);
    endtask : t_update_hold

    initial begin
        error_cnt           = 0;
        tests_run           = 0;
        rst_n               = 1'b0;
        analog_input_signal = 16'h0000;
        cfg_we              = 1'b0;
        avg_sel             = aiau_pkg::AIAU_AVG_16;
        filter_sel          = 1'b0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_conv_period();
        one_sample(16'h1234, 4);
        one_sample(16'h4321, 4);
        t_update_hold();
        set_mode(aiau_pkg::AIAU_AVG_4, 1'b1);
        for (int i = 0; i < 5; i++) begin
            one_sample(16'h0F00 + 16'(i) * 16'h1111, 2);
        end
        set_mode(aiau_pkg::AIAU_AVG_NONE, 1'b0);
        one_sample(16'hABCD, 0);
        one_sample(16'h0001, 0);
        set_mode(aiau_pkg::AIAU_AVG_32, 1'b1);
        one_sample(16'hFFFF, 5);
        one_sample(16'h8000, 5);
        wrap_up();
    end
endmodule : tb
